/* ets_edge_select.sv */
// Edge trigger select: source/polarity selection, edge status flags, register port, interrupt
//
// Design decision made here: strobed register access.
`default_nettype none
module ets_edge_select (
    input  wire logic                 clk,       // System clock, 250 MHz
    input  wire logic                 rst_b,     // Async reset, active low
    input  wire ets_pkg::ets_bus_req_t bus_req,  // Register bus request
    output logic [7:0]                rdata,     // Read data, cycle after read strobe
    input  wire ets_pkg::ets_sources_t sources,  // Event sources (pins async)
    output logic                      irq,       // Level interrupt
    output logic                      e1_trig,   // Edge 1 detected pulse
    output logic                      e2_trig    // Edge 2 detected pulse
);
    logic [7:0] ctrl_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [2:0] pin1_sync_q;
    logic [2:0] pin2_sync_q;
    logic       pin1_lvl_q;
    logic       pin2_lvl_q;
    logic       cmp_q;
    logic       tmr_q;
    logic       src1_prev_q;
    logic       src2_prev_q;
    logic       src1_d;
    logic       src2_d;
    logic       hit1;
    logic       hit2;
    logic       wr_ctrl;

    function automatic logic pick_src(input logic [1:0] sel, input logic p1, input logic p2,
                                      input logic cmp, input logic tmr);
        unique case (ets_pkg::ets_src_t'(sel))
            ets_pkg::ETS_SRC_PIN_ONE: pick_src = p1;
            ets_pkg::ETS_SRC_PIN_TWO: pick_src = p2;
            ets_pkg::ETS_SRC_COMPARE: pick_src = cmp;
            ets_pkg::ETS_SRC_TIMER:   pick_src = tmr;
        endcase
    endfunction

    function automatic logic edge_hit(input logic pol, input logic prev, input logic cur);
        edge_hit = pol ? (!prev && cur) : (prev && !cur);
    endfunction

    // Pins pass three flops; a level counts when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin1_sync_q <= 3'h0;
            pin2_sync_q <= 3'h0;
            pin1_lvl_q  <= 1'b0;
            pin2_lvl_q  <= 1'b0;
        end else begin
            pin1_sync_q <= {pin1_sync_q[1:0], sources.edge_pin_one};
            pin2_sync_q <= {pin2_sync_q[1:0], sources.edge_pin_two};
            if (pin1_sync_q[1] == pin1_sync_q[2]) begin
                pin1_lvl_q <= pin1_sync_q[2];
            end
            if (pin2_sync_q[1] == pin2_sync_q[2]) begin
                pin2_lvl_q <= pin2_sync_q[2];
            end
        end
    end

    // On-chip sources registered once; pin levels reach the selectors three cycles later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_q <= 1'b0;
            tmr_q <= 1'b0;
        end else begin
            cmp_q <= sources.output_compare_unit;
            tmr_q <= sources.timer_unit;
        end
    end

    always_comb begin
        src1_d = pick_src(ctrl_q[ets_pkg::ETS_E1_SRC_LSB +: 2], pin1_lvl_q, pin2_lvl_q,
                          cmp_q, tmr_q);
        src2_d = pick_src(ctrl_q[ets_pkg::ETS_E2_SRC_LSB +: 2], pin1_lvl_q, pin2_lvl_q,
                          cmp_q, tmr_q);
        hit1 = edge_hit(ctrl_q[ets_pkg::ETS_E1_POL_BIT], src1_prev_q, src1_d);
        hit2 = edge_hit(ctrl_q[ets_pkg::ETS_E2_POL_BIT], src2_prev_q, src2_d);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src1_prev_q <= 1'b0;
            src2_prev_q <= 1'b0;
        end else begin
            src1_prev_q <= src1_d;
            src2_prev_q <= src2_d;
        end
    end

    assign wr_ctrl = bus_req.wr && (bus_req.addr == ets_pkg::ETS_CTRL_LOW_ADDR);

    // Control fields plus status flags; a detected edge wins over a software write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= ets_pkg::ETS_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_req.wdata;
            end
            if (hit1) begin
                ctrl_q[ets_pkg::ETS_E1_SEEN_BIT] <= 1'b1;
            end
            if (hit2) begin
                ctrl_q[ets_pkg::ETS_E2_SEEN_BIT] <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= ets_pkg::ETS_IRQ_RESET;
            mask_q <= ets_pkg::ETS_IRQ_RESET;
        end else begin
            if (bus_req.wr && bus_req.addr == ets_pkg::ETS_IRQ_MASK_ADDR) begin
                mask_q <= bus_req.wdata[1:0];
            end
            if (bus_req.wr && bus_req.addr == ets_pkg::ETS_IRQ_STAT_ADDR) begin
                stat_q <= (stat_q & ~bus_req.wdata[1:0]) | {hit2, hit1};
            end else begin
                stat_q <= stat_q | {hit2, hit1};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata   <= 8'h00;
            irq     <= 1'b0;
            e1_trig <= 1'b0;
            e2_trig <= 1'b0;
        end else begin
            irq     <= |(stat_q & mask_q);
            e1_trig <= hit1;
            e2_trig <= hit2;
            rdata   <= 8'h00;
            if (bus_req.rd) begin
                unique case (bus_req.addr)
                    ets_pkg::ETS_CTRL_LOW_ADDR: rdata <= ctrl_q;
                    ets_pkg::ETS_IRQ_STAT_ADDR: rdata <= {6'h00, stat_q};
                    ets_pkg::ETS_IRQ_MASK_ADDR: rdata <= {6'h00, mask_q};
                    default:                    rdata <= 8'h00;
                endcase
            end
        end
    end

    chk_e1_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        hit1 |=> ctrl_q[ets_pkg::ETS_E1_SEEN_BIT] && stat_q[0])
        else $error("edge 1 flag not set");
    chk_e2_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
        hit2 |=> ctrl_q[ets_pkg::ETS_E2_SEEN_BIT] && stat_q[1])
        else $error("edge 2 flag not set");
    chk_e1_pin_one: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[3:2] == 2'h3 |-> src1_d == pin1_lvl_q)
        else $error("edge 1 source wrong");
    chk_e1_pin_two: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[3:2] == 2'h2 |-> src1_d == pin2_lvl_q)
        else $error("edge 1 pin two source wrong");
    chk_e1_compare_src: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[3:2] == 2'h1 |-> src1_d == cmp_q)
        else $error("edge 1 compare source wrong");
    chk_e1_timer_src: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[3:2] == 2'h0 |-> src1_d == tmr_q)
        else $error("edge 1 timer source wrong");
    chk_e2_pin_one: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[6:5] == 2'h3 |-> src2_d == pin1_lvl_q)
        else $error("edge 2 pin one source wrong");
    chk_e2_pin_two: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[6:5] == 2'h2 |-> src2_d == pin2_lvl_q)
        else $error("edge 2 source wrong");
    chk_e2_compare_src: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[6:5] == 2'h1 |-> src2_d == cmp_q)
        else $error("edge 2 compare source wrong");
    chk_e2_timer_src: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[6:5] == 2'h0 |-> src2_d == tmr_q)
        else $error("edge 2 timer source wrong");
    // Polarity judged on the registered source levels tmr_q and pin2_lvl_q, not on the edge pipeline
    chk_e1_rise_pol: assert property (@(posedge clk) disable iff (!rst_b)
        hit1 && ctrl_q[4] && ctrl_q[3:2] == 2'h0 && $stable(ctrl_q[4:2]) |-> tmr_q && !$past(tmr_q))
        else $error("edge 1 polarity wrong");
    chk_e1_fall_pol: assert property (@(posedge clk) disable iff (!rst_b)
        hit1 && !ctrl_q[4] && ctrl_q[3:2] == 2'h0 && $stable(ctrl_q[4:2]) |-> !tmr_q && $past(tmr_q))
        else $error("edge 1 falling polarity wrong");
    chk_e2_fall_pol: assert property (@(posedge clk) disable iff (!rst_b)
        hit2 && !ctrl_q[7] && ctrl_q[6:5] == 2'h2 && $stable(ctrl_q[7:5])
        |-> !pin2_lvl_q && $past(pin2_lvl_q))
        else $error("edge 2 polarity wrong");
    chk_e2_rise_pol: assert property (@(posedge clk) disable iff (!rst_b)
        hit2 && ctrl_q[7] && ctrl_q[6:5] == 2'h2 && $stable(ctrl_q[7:5])
        |-> pin2_lvl_q && !$past(pin2_lvl_q))
        else $error("edge 2 rising polarity wrong");
    chk_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[0] && !wr_ctrl |=> ctrl_q[0])
        else $error("edge 1 flag lost");
    chk_e2_flag_holds: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[1] && !wr_ctrl |=> ctrl_q[1])
        else $error("edge 2 flag lost");
    chk_e1_flag_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !ctrl_q[0] && !hit1 && !wr_ctrl |=> !ctrl_q[0])
        else $error("edge 1 flag set without event");
    chk_e2_flag_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !ctrl_q[1] && !hit2 && !wr_ctrl |=> !ctrl_q[1])
        else $error("edge 2 flag set without event");
    chk_e1_trig_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        hit1 |=> e1_trig)
        else $error("edge 1 pulse missing");
    chk_e2_trig_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        hit2 |=> e2_trig)
        else $error("edge 2 pulse missing");
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_req.rd |=> rdata == 8'h00)
        else $error("read data not cleared");
    chk_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
        hit1 && mask_q[0] && $stable(mask_q) |=> ##1 irq)
        else $error("interrupt not raised");

    cov_e1_event: cover property (@(posedge clk) disable iff (!rst_b) hit1);
    cov_e2_event: cover property (@(posedge clk) disable iff (!rst_b) hit2);
    cov_both_seen: cover property (@(posedge clk) disable iff (!rst_b) ctrl_q[1:0] == 2'h3);
    cov_irq_up: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
endmodule // ets_edge_select
`default_nettype wire

/* ets_edge_select_tb.sv */
// Testbench of the edge trigger select block
`default_nettype none
module ets_edge_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk;
    logic                  rst_b;
    ets_pkg::ets_bus_req_t bus_req;
    logic [7:0]            rdata;
    ets_pkg::ets_sources_t sources;
    logic                  irq;
    logic                  e1_trig;
    logic                  e2_trig;
    logic [3:0]            lvl;
    int                    err_count;
    int                    cmp_count;
    int                    n1;
    int                    n2;
    ets_edge_select dut_u (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
        .sources(sources), .irq(irq), .e1_trig(e1_trig), .e2_trig(e2_trig));
    ets_src_model src_u (.clk(clk), .lvl(lvl), .sources(sources));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (e1_trig === 1'b1) n1 <= n1 + 1;
    always @(posedge clk) if (e2_trig === 1'b1) n2 <= n2 + 1;
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk8(d, exp);
    endtask
    task automatic t_reset();
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, 8'h00);
        chk_reg(ets_pkg::ETS_IRQ_STAT_ADDR, 8'h00);
        chk_reg(ets_pkg::ETS_IRQ_MASK_ADDR, 8'h00);
        wr_reg(12'h000, 8'hff);
        chk_reg(12'h000, 8'h00);
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, 8'h00);
    endtask
    task automatic t_select(input int ch, input logic [1:0] src, input logic pol);
        logic [7:0] c;
        logic [7:0] own;
        logic [3:0] idle;
        int         a0;
        int         b0;
        // Other channel watches the same source with the opposite polarity
        c = (ch == 2) ? {pol, src, ~pol, src, 2'h0} : {~pol, src, pol, src, 2'h0};
        own = (ch == 2) ? 8'h02 : 8'h01;
        idle = pol ? 4'h0 : 4'hf;
        lvl <= idle;
        repeat (8) @(posedge clk);
        wr_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c);
        repeat (8) @(posedge clk);
        wr_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c);
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c);
        lvl <= idle ^ ~(4'h1 << src);
        repeat (8) @(posedge clk);
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c);
        a0 = n1;
        b0 = n2;
        lvl <= ~idle;
        repeat (8) @(posedge clk);
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c | own);
        chk8(8'(n1 - a0), {7'h00, own[0]});
        chk8(8'(n2 - b0), {7'h00, own[1]});
        wr_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c);
        a0 = n1;
        b0 = n2;
        lvl <= idle;
        repeat (8) @(posedge clk);
        chk_reg(ets_pkg::ETS_CTRL_LOW_ADDR, c | (own ^ 8'h03));
        chk8(8'(n1 - a0), {7'h00, own[1]});
        chk8(8'(n2 - b0), {7'h00, own[0]});
    endtask
    task automatic t_irq();
        int n0;
        lvl <= 4'h0;
        repeat (8) @(posedge clk);
        wr_reg(ets_pkg::ETS_CTRL_LOW_ADDR, 8'h10);
        wr_reg(ets_pkg::ETS_IRQ_STAT_ADDR, 8'h03);
        wr_reg(ets_pkg::ETS_IRQ_MASK_ADDR, 8'h01);
        chk_reg(ets_pkg::ETS_IRQ_MASK_ADDR, 8'h01);
        chk8({7'h00, irq}, 8'h00);
        n0 = n1;
        lvl <= 4'h1;
        repeat (8) @(posedge clk);
        chk8({7'h00, irq}, 8'h01);
        chk8(8'(n1 - n0), 8'h01);
        chk_reg(ets_pkg::ETS_IRQ_STAT_ADDR, 8'h01);
        wr_reg(ets_pkg::ETS_IRQ_MASK_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        chk8({7'h00, irq}, 8'h00);
        wr_reg(ets_pkg::ETS_IRQ_MASK_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        chk8({7'h00, irq}, 8'h01);
        wr_reg(ets_pkg::ETS_IRQ_STAT_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        chk8({7'h00, irq}, 8'h00);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #40000;
        err_count++;
        print_verdict();
    end
    initial begin
        rst_b = 1'b0;
        bus_req = '0;
        lvl = 4'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        for (int ch = 1; ch <= 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                t_select(ch, 2'(s), 1'b1);
                t_select(ch, 2'(s), 1'b0);
            end
        end
        t_irq();
        print_verdict();
    end
endmodule // ets_edge_select_tb
`default_nettype wire

/* ets_pkg.sv */
// Package: register map, field layout and event types of the edge trigger select block
`default_nettype none
package ets_pkg;
    localparam logic [11:0] ETS_CTRL_LOW_ADDR  = 12'hfb2;
    localparam logic [11:0] ETS_IRQ_STAT_ADDR  = 12'hfb3;
    localparam logic [11:0] ETS_IRQ_MASK_ADDR  = 12'hfb4;
    localparam int          ETS_E2_POL_BIT     = 7;
    localparam int          ETS_E2_SRC_LSB     = 5;
    localparam int          ETS_E1_POL_BIT     = 4;
    localparam int          ETS_E1_SRC_LSB     = 2;
    localparam int          ETS_E2_SEEN_BIT    = 1;
    localparam int          ETS_E1_SEEN_BIT    = 0;
    localparam logic [7:0]  ETS_CTRL_RESET     = 8'h00;
    localparam logic [1:0]  ETS_IRQ_RESET      = 2'h0;

    typedef enum logic [1:0] {
        ETS_SRC_TIMER   = 2'h0,
        ETS_SRC_COMPARE = 2'h1,
        ETS_SRC_PIN_TWO = 2'h2,
        ETS_SRC_PIN_ONE = 2'h3
    } ets_src_t;

    typedef struct packed {
        logic edge_pin_one;
        logic edge_pin_two;
        logic output_compare_unit;
        logic timer_unit;
    } ets_sources_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ets_bus_req_t;
endpackage : ets_pkg
`default_nettype wire

/* ets_src_model.sv */
// Far-side model: timer, compare unit and edge pins driving the source levels
`default_nettype none
module ets_src_model (
    input  wire logic                 clk,     // System clock
    input  wire logic [3:0]           lvl,     // Wanted levels, index = source code
    output var  ets_pkg::ets_sources_t sources // Levels seen by the block
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        sources <= lvl;
    end
endmodule // ets_src_model
`default_nettype wire
